// [design/dri_pkg.sv]
// Shared constants and types for the dual-rank DDR2 pin interface
package dri_pkg;
    localparam int DQ_W = 8;
    localparam int ADDR_W = 14;
    localparam int BA_W = 3;
    localparam int NBANK = 8;
    localparam int NRANK = 2;
    localparam int BURST = 4;
    localparam int BEAT_W = 2;
    localparam int NMR = 4;
    localparam int MR_SEL_W = 2;
    localparam int IDX_W = 1 + BA_W + BEAT_W;
    localparam int MEM_DEPTH = NRANK * NBANK * BURST;
    localparam int A10_POS = 10;
    localparam int EMR1_SEL = 1;
    localparam int STROBE_COMP_DISABLE_POS = 10;
    localparam int RDQS_EN_POS = 11;
    localparam logic [ADDR_W-1:0] MR_RST = 14'h0000;
    localparam logic [DQ_W-1:0] X4_LANES = 8'h0F;
    localparam logic [DQ_W-1:0] X8_LANES = 8'hFF;
    localparam int SYNC_W = 37;
    localparam logic [2:0] RD_LAT_CYC = 3'h4;
    localparam logic [2:0] WR_LAT_CYC = 3'h2;

    typedef enum logic [2:0]
    {
        CMD_LMR = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR = 3'h4,
        CMD_RD = 3'h5,
        CMD_BST = 3'h6,
        CMD_NOP = 3'h7
    } dri_cmd_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_BURST = 2'h3
    } dri_state_t;
endpackage

// [design/dri_beat_if.sv]
// Burst request and pin-side data path between the top and the beat engine
`timescale 1ns/1ps
`default_nettype none
interface dri_beat_if;
    import dri_pkg::*;
    logic rd_go;
    logic wr_go;
    logic go_rank;
    logic [BA_W-1:0] go_bank;
    logic x8;
    logic diff_mode;
    logic rdqs_en;
    logic [DQ_W-1:0] dq_in;
    logic dm_in;
    logic dqs_in;
    logic cur_rank;
    logic mem_we;
    logic [IDX_W-1:0] mem_idx;
    logic [DQ_W-1:0] mem_wdata;
    logic [DQ_W-1:0] mem_rdata;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
    logic dqs_out;
    logic dqs_n_oe;
    logic rdqs_oe;
    logic rdqs_n_oe;
    logic strobe_miss;
    logic busy;

    modport top
    (
        output rd_go, wr_go, go_rank, go_bank, x8, diff_mode, rdqs_en,
        output dq_in, dm_in, dqs_in, mem_rdata,
        input cur_rank, mem_we, mem_idx, mem_wdata, dq_out, dq_oe, dqs_out,
        input dqs_n_oe, rdqs_oe, rdqs_n_oe, strobe_miss, busy
    );
    modport beat
    (
        input rd_go, wr_go, go_rank, go_bank, x8, diff_mode, rdqs_en,
        input dq_in, dm_in, dqs_in, mem_rdata,
        output cur_rank, mem_we, mem_idx, mem_wdata, dq_out, dq_oe, dqs_out,
        output dqs_n_oe, rdqs_oe, rdqs_n_oe, strobe_miss, busy
    );
endinterface
`default_nettype wire

// [design/dri_rank_dec.sv]
// Command decoder, mode registers and bank state of one rank
`timescale 1ns/1ps
`default_nettype none
module dri_rank_dec
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Synchronised command pins
    input wire logic cmd_phase_i,
    input wire logic cs_n_i,
    input wire logic cke_i,
    input wire logic odt_i,
    input wire dri_pkg::dri_cmd_t cmd_i,
    input wire logic [dri_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dri_pkg::BA_W-1:0] ba_i,
    // Decoded requests and state
    output logic rd_req_o,
    output logic wr_req_o,
    output logic [dri_pkg::ADDR_W-1:0] emr1_o,
    output logic [dri_pkg::NBANK-1:0] bank_open_o,
    output logic term_on_o
);
    import dri_pkg::*;

    logic cke_ff;
    logic term_ff;
    logic accept;
    logic [ADDR_W-1:0] mr_ff [NMR];
    logic [NBANK-1:0] bank_open_ff;

    // Decoder only listens with chip select low and clock enabled
    assign accept = cmd_phase_i && !cs_n_i && cke_ff;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cke_ff <= 1'b0;
        else if (cmd_phase_i)
            cke_ff <= cke_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            term_ff <= 1'b0;
        else
            term_ff <= odt_i && cke_ff;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < NMR; i++)
                mr_ff[i] <= MR_RST;
        end
        else if (accept && cmd_i == CMD_LMR)
            mr_ff[ba_i[MR_SEL_W-1:0]] <= addr_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            bank_open_ff <= '0;
        else if (accept && cmd_i == CMD_ACT)
            bank_open_ff[ba_i] <= 1'b1;
        else if (accept && cmd_i == CMD_PRE)
        begin
            if (addr_i[A10_POS])
                bank_open_ff <= '0;
            else
                bank_open_ff[ba_i] <= 1'b0;
        end
    end

    // Accesses to a closed bank are dropped rather than faked
    assign rd_req_o = accept && cmd_i == CMD_RD && bank_open_ff[ba_i];
    assign wr_req_o = accept && cmd_i == CMD_WR && bank_open_ff[ba_i];
    assign emr1_o = mr_ff[EMR1_SEL];
    assign bank_open_o = bank_open_ff;
    assign term_on_o = term_ff;
endmodule
`default_nettype wire

// [design/dri_beat.sv]
// Four-beat burst engine: latency wait, strobe generation, write capture
`timescale 1ns/1ps
`default_nettype none
module dri_beat
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Burst path
    dri_beat_if.beat bi
);
    import dri_pkg::*;

    dri_state_t state_ff;
    logic [2:0] cnt_ff;
    logic [BEAT_W-1:0] beat_ff;
    logic dir_rd_ff;
    logic rank_ff;
    logic [BA_W-1:0] bank_ff;
    logic [DQ_W-1:0] dq_ff;
    logic dq_oe_ff;
    logic dqs_ff;
    logic dqs_prev_ff;
    logic miss_ff;
    logic rdqs_active;
    logic masked;
    logic in_burst;
    logic [DQ_W-1:0] lanes;

    assign in_burst = state_ff == ST_BURST;
    assign lanes = bi.x8 ? X8_LANES : X4_LANES;
    assign rdqs_active = bi.x8 && bi.rdqs_en;
    // Shared ball is a mask only while the redundant strobe is off
    assign masked = !rdqs_active && bi.dm_in;

    // New requests while busy are refused; one burst at a time
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            beat_ff <= '0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (bi.rd_go || bi.wr_go)
                    begin
                        state_ff <= ST_WAIT;
                        cnt_ff <= (bi.rd_go ? RD_LAT_CYC : WR_LAT_CYC) - 3'h1;
                    end
                ST_WAIT:
                    if (cnt_ff == '0)
                    begin
                        state_ff <= ST_BURST;
                        beat_ff <= '0;
                    end
                    else
                        cnt_ff <= cnt_ff - 3'h1;
                ST_BURST:
                begin
                    beat_ff <= beat_ff + 2'h1;
                    if (beat_ff == 2'(BURST - 1))
                        state_ff <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dir_rd_ff <= 1'b0;
            rank_ff <= 1'b0;
            bank_ff <= '0;
        end
        else if (state_ff == ST_IDLE && (bi.rd_go || bi.wr_go))
        begin
            dir_rd_ff <= bi.rd_go;
            rank_ff <= bi.go_rank;
            bank_ff <= bi.go_bank;
        end
    end

    // Read drive: data and strobe launched by the same edge
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dq_ff <= '0;
            dq_oe_ff <= 1'b0;
            dqs_ff <= 1'b0;
        end
        else
        begin
            dq_oe_ff <= in_burst && dir_rd_ff;
            dq_ff <= (in_burst && dir_rd_ff) ? (bi.mem_rdata & lanes) : '0;
            dqs_ff <= in_burst && dir_rd_ff && !beat_ff[0];
        end
    end

    // Each write beat must see a strobe edge; the controller places it
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dqs_prev_ff <= 1'b0;
            miss_ff <= 1'b0;
        end
        else
        begin
            dqs_prev_ff <= bi.dqs_in;
            if (state_ff == ST_IDLE && bi.wr_go)
                miss_ff <= 1'b0;
            else if (in_burst && !dir_rd_ff && bi.dqs_in == dqs_prev_ff)
                miss_ff <= 1'b1;
        end
    end

    assign bi.cur_rank = rank_ff;
    assign bi.mem_idx = {rank_ff, bank_ff, beat_ff};
    assign bi.mem_we = in_burst && !dir_rd_ff && !masked;
    assign bi.mem_wdata = bi.dq_in & lanes;
    assign bi.dq_out = dq_ff;
    assign bi.dq_oe = dq_oe_ff;
    assign bi.dqs_out = dqs_ff;
    assign bi.dqs_n_oe = dq_oe_ff && bi.diff_mode;
    assign bi.rdqs_oe = dq_oe_ff && rdqs_active;
    assign bi.rdqs_n_oe = dq_oe_ff && rdqs_active && bi.diff_mode;
    assign bi.strobe_miss = miss_ff;
    assign bi.busy = state_ff != ST_IDLE;
endmodule
`default_nettype wire

// [design/dri_top.sv]
// Dual-rank DDR2 pin interface: two rank decoders sharing one data path
`timescale 1ns/1ps
`default_nettype none
module dri_top
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Organisation strap
    input wire logic x8_org_i,
    // Command and address pins
    input wire logic [dri_pkg::NRANK-1:0] cs_n_i,
    input wire logic [dri_pkg::NRANK-1:0] cke_i,
    input wire logic [dri_pkg::NRANK-1:0] odt_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [dri_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dri_pkg::BA_W-1:0] ba_i,
    // Data pins
    input wire logic [dri_pkg::DQ_W-1:0] dq_i,
    output logic [dri_pkg::DQ_W-1:0] dq_o,
    output logic [dri_pkg::DQ_W-1:0] dq_oe_o,
    // Strobe pins
    input wire logic dqs_i,
    output logic dqs_o,
    output logic dqs_oe_o,
    output logic dqs_n_o,
    output logic dqs_n_oe_o,
    // Shared mask and redundant strobe balls
    input wire logic dm_rdqs_i,
    output logic rdqs_o,
    output logic rdqs_oe_o,
    output logic rdqs_n_o,
    output logic rdqs_n_oe_o,
    // Status
    output logic [dri_pkg::NRANK-1:0] term_on_o,
    output logic [dri_pkg::NRANK*dri_pkg::NBANK-1:0] bank_open_o,
    output logic burst_busy_o,
    output logic wr_strobe_miss_o
);
    import dri_pkg::*;

    dri_beat_if bi();

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_ff;
    logic [SYNC_W-1:0] s2_ff;
    logic [NRANK-1:0] cs_n_s;
    logic [NRANK-1:0] cke_s;
    logic [NRANK-1:0] odt_s;
    dri_cmd_t cmd_s;
    logic [ADDR_W-1:0] addr_s;
    logic [BA_W-1:0] ba_s;
    logic [DQ_W-1:0] dq_s;
    logic dqs_s;
    logic dm_s;
    logic x8_s;
    logic phase_ff;
    logic [NRANK-1:0] rd_req;
    logic [NRANK-1:0] wr_req;
    logic [ADDR_W-1:0] emr1 [NRANK];
    logic [DQ_W-1:0] mem_ff [MEM_DEPTH];
    logic [ADDR_W-1:0] cur_emr;
    logic pick;

    // Every pin passes two flops before any decode
    // Command pins packed so bits 8:6 read RAS, CAS, WE in encoding order
    assign raw = {x8_org_i, dm_rdqs_i, dqs_i, dq_i, ba_i, addr_i,
                  ras_n_i, cas_n_i, we_n_i, odt_i, cke_i, cs_n_i};

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
        end
        else
        begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
        end
    end

    // Address stops at bit 13; the two reserved balls feed nothing
    assign cs_n_s = s2_ff[1:0];
    assign cke_s = s2_ff[3:2];
    assign odt_s = s2_ff[5:4];
    assign cmd_s = dri_cmd_t'(s2_ff[8:6]);
    assign addr_s = s2_ff[22:9];
    assign ba_s = s2_ff[25:23];
    assign dq_s = s2_ff[33:26];
    assign dqs_s = s2_ff[34];
    assign dm_s = s2_ff[35];
    assign x8_s = s2_ff[36];

    // Two fast clocks per command clock: commands on one, beats on both
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            phase_ff <= 1'b0;
        else
            phase_ff <= !phase_ff;
    end

    for (genvar r = 0; r < NRANK; r++)
    begin : g_rank
        dri_rank_dec u_rank
        (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .cmd_phase_i(phase_ff),
            .cs_n_i(cs_n_s[r]),
            .cke_i(cke_s[r]),
            .odt_i(odt_s[r]),
            .cmd_i(cmd_s),
            .addr_i(addr_s),
            .ba_i(ba_s),
            .rd_req_o(rd_req[r]),
            .wr_req_o(wr_req[r]),
            .emr1_o(emr1[r]),
            .bank_open_o(bank_open_o[r*NBANK +: NBANK]),
            .term_on_o(term_on_o[r])
        );
    end

    // Both selected at once is legal only for same command; rank 0 wins the data path
    assign pick = !(rd_req[0] || wr_req[0]);
    assign bi.rd_go = |rd_req;
    assign bi.wr_go = |wr_req;
    assign bi.go_rank = pick;
    assign bi.go_bank = ba_s;
    assign bi.x8 = x8_s;
    assign bi.dq_in = dq_s;
    assign bi.dm_in = dm_s;
    assign bi.dqs_in = dqs_s;

    // Strobe modes follow the extended register of the rank in the burst
    assign cur_emr = emr1[bi.cur_rank];
    assign bi.diff_mode = !cur_emr[STROBE_COMP_DISABLE_POS];
    assign bi.rdqs_en = cur_emr[RDQS_EN_POS];

    dri_beat u_beat
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .bi(bi)
    );

    // Flop storage stands in for the array: one word per rank, bank, beat
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < MEM_DEPTH; i++)
                mem_ff[i] <= '0;
        end
        else if (bi.mem_we)
            mem_ff[bi.mem_idx] <= bi.mem_wdata;
    end

    assign bi.mem_rdata = mem_ff[bi.mem_idx];

    assign dq_o = bi.dq_out;
    assign dq_oe_o = {DQ_W{bi.dq_oe}} & (x8_s ? X8_LANES : X4_LANES);
    assign dqs_o = bi.dqs_out;
    assign dqs_oe_o = bi.dq_oe;
    assign dqs_n_o = !bi.dqs_out;
    assign dqs_n_oe_o = bi.dqs_n_oe;
    assign rdqs_o = bi.dqs_out;
    assign rdqs_oe_o = bi.rdqs_oe;
    assign rdqs_n_o = !bi.dqs_out;
    assign rdqs_n_oe_o = bi.rdqs_n_oe;
    assign burst_busy_o = bi.busy;
    assign wr_strobe_miss_o = bi.strobe_miss;
endmodule
`default_nettype wire

// [sim/dri_ctrl_model.sv]
// Controller model: command pins, write data, mask and strobe
`timescale 1ns/1ps
`default_nettype none
module dri_ctrl_model
(
    // Clock and burst status
    input wire logic clk_i,
    input wire logic busy_i,
    // Command pins
    output logic [1:0] cs_n_o,
    output logic [1:0] cke_o,
    output logic [2:0] rcw_n_o,
    output logic [13:0] addr_o,
    output logic [2:0] ba_o,
    // Write data pins
    output logic [7:0] dq_o,
    output logic dqs_o,
    output logic dm_o
);
    logic flat_dqs;

    initial
    begin
        flat_dqs = 1'b0;
        cs_n_o = 2'b11;
        cke_o = 2'b11;
        rcw_n_o = 3'b111;
        addr_o = 14'h0000;
        ba_o = 3'h0;
        dq_o = 8'h00;
        dqs_o = 1'b0;
        dm_o = 1'b0;
    end

    // Held two clocks so one command phase always sees it
    task automatic cmd(input logic [1:0] cs, input logic [2:0] rcw, input logic [2:0] ba,
                       input logic [13:0] a);
        @(negedge clk_i);
        cs_n_o = cs; // One rank per command
        rcw_n_o = rcw;
        ba_o = ba;
        addr_o = a;
        repeat (2) @(negedge clk_i);
        cs_n_o = 2'b11;
        rcw_n_o = 3'b111;
        addr_o = ~a;
        ba_o = ~ba;
    endtask

    // Beats start on the edge after busy shows the write taken
    task automatic wr(input logic [1:0] cs, input logic [2:0] ba, input logic [31:0] d,
                      input logic [3:0] m);
        int i;
        cmd(cs, 3'b100, ba, 14'h0000);
        for (i = 0; i < 6 && busy_i !== 1'b1; i++) @(negedge clk_i);
        for (i = 0; i < 4; i++)
        begin
            dq_o = d[8*i+:8];
            dm_o = m[i];
            dqs_o = flat_dqs ? dqs_o : ~dqs_o; // One edge per beat, together with the data change
            @(negedge clk_i);
        end
        // Released lines must not keep the last beat
        dq_o = ~dq_o;
        dm_o = ~dm_o;
        repeat (3) @(negedge clk_i);
    endtask

    // Bench knobs: per-rank clock enables, and a strobe that never toggles
    task automatic setup(input logic [1:0] cke, input logic flat);
        cke_o = cke;
        flat_dqs = flat;
    endtask
endmodule
`default_nettype wire

// [sim/dri_top_asserts.sv]
// Concurrent checks on the pin interface ports
`timescale 1ns/1ps
`default_nettype none
module dri_top_asserts
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Watched pins
    input wire logic x8_org_i,
    input wire logic [1:0] cs_n_i,
    input wire logic [1:0] odt_i,
    input wire logic [7:0] dq_oe_o,
    input wire logic dqs_o,
    input wire logic dqs_oe_o,
    input wire logic dqs_n_oe_o,
    input wire logic rdqs_o,
    input wire logic rdqs_oe_o,
    input wire logic rdqs_n_oe_o,
    input wire logic [1:0] term_on_o,
    input wire logic [15:0] bank_open_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    chk_x4_lanes_off: assert property (
        (!x8_org_i) [*4] |-> !rdqs_oe_o && dq_oe_o[7:4] == 4'h0)
        else $error("x4 upper lanes or redundant strobe driven");
    chk_deselect_ignored: assert property (
        (cs_n_i == 2'b11) [*3] |=> $stable(bank_open_o))
        else $error("bank state changed while deselected");
    chk_term_off: assert property (
        (odt_i == 2'b00) [*4] |-> term_on_o == 2'b00)
        else $error("termination on without request");
    chk_comp_strobe: assert property (
        dqs_n_oe_o |-> dqs_oe_o)
        else $error("complement strobe without strobe");
    chk_rdqs_comp: assert property (
        rdqs_n_oe_o |-> rdqs_oe_o && dqs_n_oe_o)
        else $error("complement redundant strobe alone");
    chk_rdqs_follow: assert property (
        rdqs_oe_o |-> dqs_oe_o && rdqs_o == dqs_o && dq_oe_o == 8'hFF)
        else $error("redundant strobe off x8 read data");
    chk_read_edges: assert property (
        dqs_oe_o && $past(dqs_oe_o) |-> dqs_o != $past(dqs_o))
        else $error("read strobe missed an edge");
    chk_four_beats: assert property (
        $rose(dqs_oe_o) |-> dqs_oe_o [*4] ##1 !dqs_oe_o)
        else $error("read burst not four beats");
endmodule
bind dri_top dri_top_asserts dri_top_asserts_inst
(
    .clk_i, .nrst_i, .x8_org_i, .cs_n_i, .odt_i, .dq_oe_o, .dqs_o, .dqs_oe_o, .dqs_n_oe_o,
    .rdqs_o, .rdqs_oe_o, .rdqs_n_oe_o, .term_on_o, .bank_open_o
);
`default_nettype wire

// [sim/tb.sv]
// Testbench: ranks, bursts, mask and strobe modes through the controller model
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i, nrst_i, x8_org_i, dqs_i, dm_rdqs_i, dqs_o, dqs_oe_o, dqs_n_oe_o;
    logic rdqs_oe_o, rdqs_n_oe_o, burst_busy_o, wr_strobe_miss_o, dqs_n_o, rdqs_o, rdqs_n_o;
    logic [1:0] cs_n_i, cke_i, odt_i, term_on_o;
    logic [2:0] rcw_n, ba_i;
    logic [13:0] addr_i;
    logic [7:0] dq_i, dq_o, dq_oe_o;
    logic [15:0] bank_open_o;
    logic [2:0] mode_ba [5] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h1};
    logic [13:0] mode_op [5] = '{14'h0000, 14'h0800, 14'h0C00, 14'h0000, 14'h0400};
    logic [2:0] mode_st [5] = '{3'b100, 3'b111, 3'b010, 3'b010, 3'b000};
    int n_fail = 0;
    int comparisons = 0;

    dri_top dri_top_inst
    (
        .clk_i, .nrst_i, .x8_org_i, .cs_n_i, .cke_i, .odt_i,
        .ras_n_i(rcw_n[2]), .cas_n_i(rcw_n[1]), .we_n_i(rcw_n[0]),
        .addr_i, .ba_i, .dq_i, .dq_o, .dq_oe_o, .dqs_i, .dqs_o, .dqs_oe_o,
        .dqs_n_o, .dqs_n_oe_o, .dm_rdqs_i, .rdqs_o, .rdqs_oe_o, .rdqs_n_o,
        .rdqs_n_oe_o, .term_on_o, .bank_open_o, .burst_busy_o, .wr_strobe_miss_o
    );

    dri_ctrl_model dri_ctrl_model_inst
    (
        .clk_i, .busy_i(burst_busy_o), .cs_n_o(cs_n_i), .cke_o(cke_i), .rcw_n_o(rcw_n),
        .addr_o(addr_i), .ba_o(ba_i), .dq_o(dq_i), .dqs_o(dqs_i), .dm_o(dm_rdqs_i)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic op(input logic [1:0] cs, input logic [2:0] rcw, input logic [2:0] ba,
                      input logic [13:0] a);
        dri_ctrl_model_inst.cmd(cs, rcw, ba, a);
        repeat (2) @(negedge clk_i);
    endtask

    // Strobe flags in st: complement, redundant, complement redundant
    task automatic rd(input logic [1:0] cs, input logic [2:0] ba, input logic [31:0] d,
                      input logic [7:0] oe, input logic [2:0] st);
        int i;
        dri_ctrl_model_inst.cmd(cs, 3'b101, ba, 14'h0000);
        for (i = 0; i < 12 && dq_oe_o[0] !== 1'b1; i++) @(negedge clk_i);
        chk("rd_lanes", {burst_busy_o, dq_oe_o}, {1'b1, oe});
        chk("rd_strobes", {dqs_n_oe_o, rdqs_oe_o, rdqs_n_oe_o}, st);
        for (i = 0; i < 4; i++)
        begin
            chk("rd_data", dq_o & oe, d[8*i+:8] & oe);
            chk("rd_dqs", {dqs_o, dqs_n_o, rdqs_o, rdqs_n_o}, {2{~i[0], i[0]}});
            @(negedge clk_i);
        end
        // Four beats only: drivers off and engine free after the last
        chk("rd_end", {burst_busy_o, dq_oe_o}, 9'h000);
    endtask

    initial
    begin
        nrst_i = 1'b0;
        x8_org_i = 1'b1;
        odt_i = 2'b00;
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk("term_off", term_on_o, 2'b00);
        odt_i = 2'b11;
        op(2'b10, 3'b011, 3'h2, 14'h0000);
        chk("open_r0", {term_on_o, bank_open_o}, 18'h30004);
        op(2'b01, 3'b011, 3'h2, 14'h0000);
        chk("open_r1", bank_open_o, 16'h0404);
        op(2'b11, 3'b011, 3'h5, 14'h0000);
        chk("deselect", bank_open_o, 16'h0404);
        dri_ctrl_model_inst.setup(2'b01, 1'b0);
        op(2'b01, 3'b011, 3'h6, 14'h0000);
        chk("cke_low", {term_on_o, bank_open_o}, 18'h10404);
        dri_ctrl_model_inst.setup(2'b11, 1'b0);
        dri_ctrl_model_inst.wr(2'b10, 3'h2, 32'h44332211, 4'h0);
        dri_ctrl_model_inst.wr(2'b01, 3'h2, 32'h88776655, 4'h0);
        dri_ctrl_model_inst.wr(2'b10, 3'h2, 32'hDDCCBBAA, 4'h2);
        chk("strobe_miss", wr_strobe_miss_o, 1'b0);
        rd(2'b01, 3'h2, 32'h88776655, 8'hFF, 3'b100);
        rd(2'b10, 3'h2, 32'hDDCC22AA, 8'hFF, 3'b100);
        for (int k = 0; k < 5; k++)
        begin
            op(2'b10, 3'b000, mode_ba[k], mode_op[k]);
            rd(2'b10, 3'h2, 32'hDDCC22AA, 8'hFF, mode_st[k]);
        end
        op(2'b10, 3'b000, 3'h1, 14'h0800);
        dri_ctrl_model_inst.wr(2'b10, 3'h2, 32'h01020304, 4'hF);
        rd(2'b10, 3'h2, 32'h01020304, 8'hFF, 3'b111);
        op(2'b10, 3'b010, 3'h2, 14'h0000);
        chk("pre_one", bank_open_o, 16'h0400);
        op(2'b01, 3'b011, 3'h3, 14'h0000);
        op(2'b01, 3'b010, 3'h0, 14'h0400);
        chk("pre_all", bank_open_o, 16'h0000);
        // Read to a closed bank is dropped: the engine never starts
        op(2'b01, 3'b101, 3'h0, 14'h0000);
        chk("rd_closed", burst_busy_o, 1'b0);
        x8_org_i = 1'b0;
        op(2'b10, 3'b011, 3'h1, 14'h0000);
        dri_ctrl_model_inst.wr(2'b10, 3'h1, 32'hA5B6C7D8, 4'h0);
        rd(2'b10, 3'h1, 32'hA5B6C7D8, 8'h0F, 3'b100);
        // Strobe held flat through a write must raise the miss flag
        dri_ctrl_model_inst.setup(2'b11, 1'b1);
        dri_ctrl_model_inst.wr(2'b10, 3'h1, 32'h00000000, 4'h0);
        chk("strobe_miss_set", wr_strobe_miss_o, 1'b1);
        dri_ctrl_model_inst.setup(2'b11, 1'b0);
        dri_ctrl_model_inst.wr(2'b10, 3'h1, 32'h00000000, 4'h0);
        chk("strobe_miss_clr", wr_strobe_miss_o, 1'b0);
        stop_test;
    end

    // Whole run is a few hundred cycles at most
    initial
    begin
        #20us;
        n_fail++;
        stop_test;
    end
endmodule
`default_nettype wire
